// ===== homing_pkg.sv
package homing_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_VEL_SENSE = 8'h08;
  localparam logic [7:0] OFS_VEL_OFS   = 8'h0C;
  localparam logic [7:0] OFS_OFS_DIST  = 8'h10;
  localparam logic [7:0] OFS_DONE_CMD  = 8'h14;
  localparam logic [7:0] OFS_MEAS      = 8'h18;
  localparam logic [7:0] OFS_INTERVAL  = 8'h1C;
  localparam logic [7:0] OFS_COORD     = 8'h20;
  localparam logic [7:0] OFS_CORR_DIST = 8'h24;

  // control field positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_SOFT_Z = 1;
  localparam int CTRL_DIR    = 2;

  // status field positions
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_RES_LO   = 2;
  localparam int ST_FAIL     = 4;

  // reset values
  localparam logic [31:0] RST_VEL_SENSE = 32'h0000_0100;
  localparam logic [31:0] RST_VEL_OFS   = 32'h0000_0100;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] INT_VEL       = 32'h0000_0080; // internal edge-move velocity

  // distance outcome codes
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_NORM = 2'h1,
    RES_WARN = 2'h2,
    RES_ERR  = 2'h3
  } result_e;

  // thresholds as fractions num/den of the zero interval
  localparam int LOW_ERR_NUM  = 1;   // 0.05 = 1/20
  localparam int LOW_ERR_DEN  = 20;
  localparam int LOW_WARN_NUM = 1;   // 0.1 = 1/10
  localparam int LOW_WARN_DEN = 10;
  localparam int HW_NORM_NUM  = 7;   // 0.7
  localparam int HW_NORM_DEN  = 10;
  localparam int HW_WARN_NUM  = 3;   // 0.75
  localparam int HW_WARN_DEN  = 4;
  localparam int SW_NORM_NUM  = 2;   // 0.4
  localparam int SW_NORM_DEN  = 5;
  localparam int SW_WARN_NUM  = 9;   // 0.45
  localparam int SW_WARN_DEN  = 20;

endpackage : homing_pkg

// ===== enc_front.sv
`timescale 1ns/1ps
module enc_front
  import homing_pkg::*;
#(
  parameter int POS_W = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // pins
  input  wire logic             enc_step,
  input  wire logic             enc_zero,
  input  wire logic             prox,
  // decoded events
  output logic                  step_p,
  output logic                  zero_p,
  output logic                  prox_fall_p,
  output logic [POS_W-1:0]      interval
);

  initial begin
    if (POS_W < 8 || POS_W > 32) $error("enc_front: POS_W out of range");
  end

  typedef struct packed {
    logic [2:0]       s1;
    logic [2:0]       s2;
    logic [2:0]       s3;
    logic [2:0]       warm;
    logic [POS_W-1:0] cnt;
    logic [POS_W-1:0] iv;
    logic             step;
    logic             zero;
    logic             pfall;
  } fe_s;

  fe_s st_q;
  fe_s st_d;

  // s1 only feeds s2; edges are taken between s2 and s3
  always_comb begin
    st_d       = st_q;
    st_d.s1    = {enc_step, enc_zero, prox};
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    // edges wait until s3 holds a real sample, so reset gives no false edge
    st_d.warm  = {st_q.warm[1:0], 1'b1};
    st_d.step  = st_q.warm[2] & st_q.s2[2] & ~st_q.s3[2];
    st_d.zero  = st_q.warm[2] & st_q.s2[1] & ~st_q.s3[1];
    st_d.pfall = st_q.warm[2] & ~st_q.s2[0] & st_q.s3[0];
    // pulses between zero edges give the interval; the pulse on the edge counts
    if (st_d.zero) begin
      st_d.iv  = st_q.cnt + POS_W'(st_d.step);
      st_d.cnt = '0;
    end else if (st_d.step) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign step_p      = st_q.step;
  assign zero_p      = st_q.zero;
  assign prox_fall_p = st_q.pfall;
  assign interval    = st_q.iv;

endmodule : enc_front

// ===== dist_judge.sv
`timescale 1ns/1ps
module dist_judge
  import homing_pkg::*;
#(
  parameter int POS_W = 32
) (
  // operands
  input  wire logic [POS_W-1:0] meas,
  input  wire logic [POS_W-1:0] interval,
  input  wire logic             soft_zero,
  // outcome
  output result_e               result
);

  localparam int PW = POS_W + 8;

  // scaled compare: meas*den against interval*num, no division needed
  function automatic logic below(input logic [POS_W-1:0] m, input logic [POS_W-1:0] iv,
                                 input int num, input int den, input logic incl);
    logic [PW-1:0] a;
    logic [PW-1:0] b;
    a = PW'(m) * PW'(den);
    b = PW'(iv) * PW'(num);
    below = incl ? (a <= b) : (a < b);
  endfunction : below

  always_comb begin
    if (below(meas, interval, LOW_ERR_NUM, LOW_ERR_DEN, 1'b0)) begin
      result = RES_ERR;
    end else if (below(meas, interval, LOW_WARN_NUM, LOW_WARN_DEN, 1'b0)) begin
      result = RES_WARN;
    end else if (soft_zero) begin
      if (below(meas, interval, SW_NORM_NUM, SW_NORM_DEN, 1'b1)) begin
        result = RES_NORM;
      end else if (below(meas, interval, SW_WARN_NUM, SW_WARN_DEN, 1'b1)) begin
        result = RES_WARN;
      end else begin
        result = RES_ERR;
      end
    end else if (below(meas, interval, HW_NORM_NUM, HW_NORM_DEN, 1'b1)) begin
      result = RES_NORM;
    end else if (below(meas, interval, HW_WARN_NUM, HW_WARN_DEN, 1'b1)) begin
      result = RES_WARN;
    end else begin
      result = RES_ERR;
    end
  end

endmodule : dist_judge

// ===== homing_zero_edge_sequencer.sv
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - The second zero-edge sensing runs as a preparation move followed by an edge search move.
// - Preparation moves half a zero interval against the first search direction at sense velocity.
// - The search moves in the first search direction at sense velocity until the zero edge.
// - The rotor then returns to the detected edge at an internally chosen velocity.
// - With a software zero signal an extra corrective move follows the edge move.
// - Then the offset distance is moved and the command coordinate loads the completion value.
// - The offset move runs at the offset feed velocity setting.
// - Pulses from leaving the proximity area to the first zero edge are counted and readable.
// - Success is judged from the measured distance against fractions of the zero interval.
// - Below 0.05 of the interval is an error, from 0.05 below 0.1 a warning.
// - With a hardware zero, 0.1 to 0.7 is normal, up to 0.75 a warning, beyond an error.
// - With a software zero, up to 0.4 is normal and up to 0.45 a warning.
module homing_zero_edge_sequencer
  import homing_pkg::*;
#(
  parameter int POS_W = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // encoder and sensor pins
  input  wire logic             enc_step,
  input  wire logic             enc_zero,
  input  wire logic             prox,
  // motion command port
  output logic                  mv_req,
  output logic                  mv_cont,
  output logic                  mv_stop,
  output logic                  mv_dir,
  output logic [POS_W-1:0]      mv_dist,
  output logic [31:0]           mv_vel,
  input  wire logic             mv_done,
  // status pins
  output logic                  busy,
  output logic                  homed_ok,
  output logic [1:0]            homing_result
);

  initial begin
    if (POS_W < 8 || POS_W > 32) $error("homing_zero_edge_sequencer: POS_W out of range");
  end

  typedef enum logic [10:0] {
    S_IDLE   = 11'b000_0000_0001,
    S_MEAS   = 11'b000_0000_0010,
    S_COUNT  = 11'b000_0000_0100,
    S_CHECK  = 11'b000_0000_1000,
    S_PREP   = 11'b000_0001_0000,
    S_SEARCH = 11'b000_0010_0000,
    S_EDGE   = 11'b000_0100_0000,
    S_CORR   = 11'b000_1000_0000,
    S_OFFSET = 11'b001_0000_0000,
    S_LOAD   = 11'b010_0000_0000,
    S_FAIL   = 11'b100_0000_0000
  } state_e;

  typedef struct packed {
    state_e           st;
    logic             issued;     // move of this phase already requested
    logic             edge_seen;  // zero edge met during search
    logic             soft_zero;
    logic             dir;        // first sensing search direction
    logic [31:0]      vel_sense;
    logic [31:0]      vel_ofs;
    logic [POS_W-1:0] ofs_dist;
    logic [31:0]      done_cmd;
    logic [POS_W-1:0] corr_dist;
    logic [POS_W-1:0] meas;
    logic [POS_W-1:0] over;       // overshoot past the edge
    logic [31:0]      coord;
    logic             done;
    result_e          res;
    logic             req;
    logic             cont;
    logic             stop;
    logic             mdir;
    logic [POS_W-1:0] mdist;
    logic [31:0]      mvel;
    logic [31:0]      rdata;
    logic             err;
  } seq_s;

  seq_s st_q;
  seq_s st_d;

  logic             step_p;
  logic             zero_p;
  logic             prox_fall_p;
  logic [POS_W-1:0] interval;
  result_e          judge;

  // synchronised encoder events and zero interval monitor
  enc_front #(.POS_W(POS_W)) u_front (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .enc_step    (enc_step),
    .enc_zero    (enc_zero),
    .prox        (prox),
    .step_p      (step_p),
    .zero_p      (zero_p),
    .prox_fall_p (prox_fall_p),
    .interval    (interval)
  );

  // distance grading from the latched measurement
  dist_judge #(.POS_W(POS_W)) u_judge (
    .meas      (st_q.meas),
    .interval  (interval),
    .soft_zero (st_q.soft_zero),
    .result    (judge)
  );

  // apb phase decode
  logic setup_ph;
  logic wr_en;
  logic start_wr;
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign start_wr = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_START];

  // a known register address; used by the error answer only, the read mux decodes on its own
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == OFS_CTRL) begin
      is_mapped = 1'b1;
    end else if (a == OFS_STATUS || a == OFS_VEL_SENSE || a == OFS_VEL_OFS) begin
      is_mapped = 1'b1;
    end else if (a == OFS_OFS_DIST || a == OFS_DONE_CMD || a == OFS_MEAS) begin
      is_mapped = 1'b1;
    end else if (a == OFS_INTERVAL || a == OFS_COORD || a == OFS_CORR_DIST) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction : is_mapped

  logic [31:0] status_w;
  assign status_w = {27'h0, st_q.err, st_q.res, st_q.done, (st_q.st != S_IDLE)};

  // half an interval: the point diametrically opposite the edge
  logic [POS_W-1:0] half_iv;
  assign half_iv = {1'b0, interval[POS_W-1:1]};

  always_comb begin
    st_d      = st_q;
    st_d.req  = 1'b0;
    st_d.stop = 1'b0;

    // register writes; settings only change while the sequencer is idle
    if (wr_en && st_q.st == S_IDLE) begin
      if (paddr == OFS_CTRL) begin
        st_d.soft_zero = pwdata[CTRL_SOFT_Z];
        st_d.dir       = pwdata[CTRL_DIR];
      end else if (paddr == OFS_VEL_SENSE) begin
        st_d.vel_sense = pwdata;
      end else if (paddr == OFS_VEL_OFS) begin
        st_d.vel_ofs = pwdata;
      end else if (paddr == OFS_OFS_DIST) begin
        st_d.ofs_dist = pwdata[POS_W-1:0];
      end else if (paddr == OFS_DONE_CMD) begin
        st_d.done_cmd = pwdata;
      end else if (paddr == OFS_CORR_DIST) begin
        st_d.corr_dist = pwdata[POS_W-1:0];
      end
    end

    // read data is latched in the setup cycle so it comes from a flop
    if (setup_ph) begin
      if (paddr == OFS_CTRL) begin
        st_d.rdata = {29'h0, st_q.dir, st_q.soft_zero, 1'b0};
      end else if (paddr == OFS_STATUS) begin
        st_d.rdata = status_w;
      end else if (paddr == OFS_VEL_SENSE) begin
        st_d.rdata = st_q.vel_sense;
      end else if (paddr == OFS_VEL_OFS) begin
        st_d.rdata = st_q.vel_ofs;
      end else if (paddr == OFS_OFS_DIST) begin
        st_d.rdata = 32'(st_q.ofs_dist);
      end else if (paddr == OFS_DONE_CMD) begin
        st_d.rdata = st_q.done_cmd;
      end else if (paddr == OFS_MEAS) begin
        st_d.rdata = 32'(st_q.meas);
      end else if (paddr == OFS_INTERVAL) begin
        st_d.rdata = 32'(interval);
      end else if (paddr == OFS_COORD) begin
        st_d.rdata = st_q.coord;
      end else if (paddr == OFS_CORR_DIST) begin
        st_d.rdata = 32'(st_q.corr_dist);
      end else begin
        st_d.rdata = 32'h0000_0000;
      end
    end

    case (st_q.st)
      S_IDLE: begin
        if (start_wr) begin
          st_d.st        = S_MEAS;
          st_d.soft_zero = pwdata[CTRL_SOFT_Z];
          st_d.dir       = pwdata[CTRL_DIR];
          st_d.done      = 1'b0;
          st_d.err       = 1'b0;
          st_d.res       = RES_NONE;
          st_d.meas      = '0;
        end
      end
      // wait for the rotor to leave the proximity area
      S_MEAS: begin
        if (prox_fall_p) begin
          st_d.st   = S_COUNT;
          st_d.meas = '0;
        end
      end
      // count pulses up to the first zero edge
      S_COUNT: begin
        if (zero_p) begin
          st_d.st   = S_CHECK;
          st_d.meas = st_q.meas + POS_W'(step_p);  // pulse landing on the edge counts
        end else if (step_p) begin
          st_d.meas = st_q.meas + 1'b1;
        end
      end
      // grade the distance; an error stops before any move
      S_CHECK: begin
        st_d.res = judge;
        if (judge == RES_ERR) begin
          st_d.st  = S_FAIL;
          st_d.err = 1'b1;
        end else begin
          st_d.st     = S_PREP;
          st_d.issued = 1'b0;
        end
      end
      S_PREP: begin
        if (!st_q.issued) begin
          st_d.issued = 1'b1;
          st_d.req    = 1'b1;
          st_d.cont   = 1'b0;
          st_d.mdir   = ~st_q.dir;
          st_d.mdist  = half_iv;
          st_d.mvel   = st_q.vel_sense;
        end else if (mv_done) begin
          st_d.st        = S_SEARCH;
          st_d.issued    = 1'b0;
          st_d.edge_seen = 1'b0;
          st_d.over      = '0;
        end
      end
      // open-ended move, stopped by the zero edge; overshoot is counted
      S_SEARCH: begin
        if (!st_q.issued) begin
          st_d.issued = 1'b1;
          st_d.req    = 1'b1;
          st_d.cont   = 1'b1;
          st_d.mdir   = st_q.dir;
          st_d.mdist  = '0;
          st_d.mvel   = st_q.vel_sense;
        end else begin
          if (zero_p && !st_q.edge_seen) begin
            st_d.edge_seen = 1'b1;
            st_d.stop      = 1'b1;
          end else if (step_p && st_q.edge_seen) begin
            st_d.over = st_q.over + 1'b1;
          end
          if (mv_done && st_q.edge_seen) begin
            st_d.st     = S_EDGE;
            st_d.issued = 1'b0;
            st_d.cont   = 1'b0;
          end
        end
      end
      // back to the edge at the internal velocity
      S_EDGE: begin
        if (!st_q.issued) begin
          st_d.issued = 1'b1;
          st_d.req    = 1'b1;
          st_d.mdir   = ~st_q.dir;
          st_d.mdist  = st_q.over;
          st_d.mvel   = INT_VEL;
        end else if (mv_done) begin
          st_d.issued = 1'b0;
          st_d.st     = st_q.soft_zero ? S_CORR : S_OFFSET;
        end
      end
      S_CORR: begin
        if (!st_q.issued) begin
          st_d.issued = 1'b1;
          st_d.req    = 1'b1;
          st_d.mdir   = st_q.dir;
          st_d.mdist  = st_q.corr_dist;
          st_d.mvel   = INT_VEL;
        end else if (mv_done) begin
          st_d.issued = 1'b0;
          st_d.st     = S_OFFSET;
        end
      end
      S_OFFSET: begin
        if (!st_q.issued) begin
          st_d.issued = 1'b1;
          st_d.req    = 1'b1;
          st_d.mdir   = st_q.dir;
          st_d.mdist  = st_q.ofs_dist;
          st_d.mvel   = st_q.vel_ofs;
        end else if (mv_done) begin
          st_d.issued = 1'b0;
          st_d.st     = S_LOAD;
        end
      end
      S_LOAD: begin
        st_d.coord = st_q.done_cmd;
        st_d.done  = 1'b1;
        st_d.st    = S_IDLE;
      end
      S_FAIL: begin
        st_d.st = S_IDLE;
      end
      default: begin
        st_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q           <= '0;
      st_q.st        <= S_IDLE;
      st_q.res       <= RES_NONE;
      st_q.vel_sense <= RST_VEL_SENSE;
      st_q.vel_ofs   <= RST_VEL_OFS;
      st_q.done_cmd  <= RST_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  // apb answer: zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata  = st_q.rdata;

  // motion command and status outputs
  assign mv_req        = st_q.req;
  assign mv_cont       = st_q.cont;
  assign mv_stop       = st_q.stop;
  assign mv_dir        = st_q.mdir;
  assign mv_dist       = st_q.mdist;
  assign mv_vel        = st_q.mvel;
  assign busy          = (st_q.st != S_IDLE);
  assign homed_ok      = st_q.done & ~st_q.err;
  assign homing_result = st_q.res;

endmodule : homing_zero_edge_sequencer

// ===== homing_assertions.sv
`timescale 1ns/1ps
module homing_checker
  import homing_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // motion command port
  input wire logic        mv_req,
  input wire logic        mv_cont,
  input wire logic        mv_stop,
  input wire logic        mv_dir,
  input wire logic [31:0] mv_vel,
  // status pins
  input wire logic        busy,
  input wire logic        homed_ok,
  input wire logic [1:0]  homing_result
);
  // one clock domain, so one clocking and one disable for all checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // direction of the last positioned move and of the last open-ended search
  logic pdir_q;
  logic sdir_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdir_q <= 1'b0;
      sdir_q <= 1'b0;
    end else if (mv_req && mv_cont) begin
      sdir_q <= mv_dir;
    end else if (mv_req) begin
      pdir_q <= mv_dir;
    end
  end

  a_req_pulse: assert property (mv_req |=> !mv_req)
    else $error("move request wider than one cycle");
  a_search_dir: assert property (mv_req && mv_cont |-> mv_dir != pdir_q)
    else $error("search move not against the preparation move");
  a_search_stop: assert property (mv_req && mv_cont |-> ##[1:1000] mv_stop)
    else $error("search move never stopped");
  a_stop_pulse: assert property (mv_stop |=> !mv_stop)
    else $error("stop wider than one cycle");
  // the slowest partner answer plus the restart gap fits well inside 60
  a_edge_move: assert property (mv_stop |-> ##[2:60] (mv_req && mv_dir != sdir_q && !mv_cont
    && mv_vel == INT_VEL))
    else $error("no edge return move at internal velocity");
  a_err_not_ok: assert property (homing_result == RES_ERR |-> !homed_ok)
    else $error("error outcome shown as completed");
  a_ok_result: assert property ($rose(homed_ok) |-> !busy
    && homing_result inside {RES_NORM, RES_WARN})
    else $error("completion without a good outcome");
  a_err_no_move: assert property (homing_result == RES_ERR && !busy |-> !mv_req)
    else $error("move after error outcome");
endmodule : homing_checker

// ===== motor_model.sv
`timescale 1ns/1ps
module motor_model #(
  parameter int ZI = 200
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // move commands from the sequencer
  input  wire logic        mv_req,
  input  wire logic        mv_cont,
  input  wire logic        mv_stop,
  input  wire logic        mv_dir,
  input  wire logic [31:0] mv_dist,
  // bench controls
  input  wire logic        seek,
  input  wire logic [31:0] prox_at,
  input  wire logic [31:0] done_dly,
  // encoder, sensor and answer
  output logic             enc_step,
  output logic             enc_zero,
  output logic             prox,
  output logic             mv_done,
  output int               pos
);
  int   rem;
  int   ph;
  int   dcnt;
  logic run;
  logic cont;
  logic dir;
  logic skm;

  // zero signal is high for half of every interval, rising at multiples of ZI
  assign enc_zero = (pos % ZI) < (ZI / 2);
  assign prox     = pos < int'(prox_at);

  // one pulse every four cycles while moving; done may be held back by done_dly
  always @(posedge clk_sys) begin
    if (rst) begin
      pos <= 1010;
      run <= 1'b0;
      skm <= 1'b0;
      ph <= 0;
      dcnt <= 0;
      enc_step <= 1'b0;
      mv_done <= 1'b0;
    end else begin
      mv_done <= (dcnt == 1);
      ph <= (ph == 3) ? 0 : ph + 1;
      if (dcnt > 0) dcnt <= dcnt - 1;
      if (ph == 2) enc_step <= 1'b0;
      if (ph == 0 && (skm || run)) begin
        enc_step <= 1'b1;
        pos <= dir ? pos + 1 : pos - 1;
        rem <= rem - 1;
        // first sensing ends at the first zero edge outside the proximity area
        if (skm && (pos + 1) % ZI == 0 && pos + 1 >= int'(prox_at)) skm <= 1'b0;
        if (run && !cont && rem == 1) begin
          run <= 1'b0;
          dcnt <= 1 + done_dly;
        end
      end
      if (seek) begin
        skm <= 1'b1;
        dir <= 1'b1;
      end
      if (mv_req) begin
        run <= mv_cont || mv_dist != 0;
        cont <= mv_cont;
        dir <= mv_dir;
        rem <= int'(mv_dist);
        if (!mv_cont && mv_dist == 0) dcnt <= 2 + done_dly;
      end
      if (mv_stop) begin
        run <= 1'b0;
        dcnt <= 3 + done_dly;
      end
    end
  end
endmodule : motor_model

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb
  import homing_pkg::*;
;
  typedef struct {int d; logic sw; int dly; logic [1:0] res;} row_s;
  logic        clk_sys, rst, psel, penable, pwrite, seek, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mv_dist, mv_vel, prox_at, rdat;
  logic        pready, pslverr, enc_step, enc_zero, prox, mv_req, mv_cont, mv_stop;
  logic        mv_dir, mv_done, busy, homed_ok;
  logic [1:0]  homing_result;
  int          miscompares, cmp_count, done_dly, pos, n, z;
  logic [31:0] lv [8], ld [8];
  logic        lr [8], lc [8];
  // distances sit two pulses off each threshold of a 200-pulse interval
  row_s rows [10] = '{
    '{8, 1'b0, 0, 2'h3}, '{12, 1'b0, 0, 2'h2}, '{22, 1'b0, 15, 2'h1},
    '{138, 1'b0, 0, 2'h1}, '{148, 1'b0, 0, 2'h2}, '{152, 1'b0, 0, 2'h3},
    '{18, 1'b1, 0, 2'h2}, '{78, 1'b1, 0, 2'h1}, '{88, 1'b1, 20, 2'h2},
    '{92, 1'b1, 0, 2'h3}};

  homing_zero_edge_sequencer #(.POS_W(32)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_step(enc_step), .enc_zero(enc_zero),
    .prox(prox), .mv_req(mv_req), .mv_cont(mv_cont), .mv_stop(mv_stop), .mv_dir(mv_dir),
    .mv_dist(mv_dist), .mv_vel(mv_vel), .mv_done(mv_done), .busy(busy),
    .homed_ok(homed_ok), .homing_result(homing_result));
  motor_model #(.ZI(200)) model_u (.clk_sys(clk_sys), .rst(rst), .mv_req(mv_req),
    .mv_cont(mv_cont), .mv_stop(mv_stop), .mv_dir(mv_dir), .mv_dist(mv_dist), .seek(seek),
    .prox_at(prox_at), .done_dly(done_dly), .enc_step(enc_step), .enc_zero(enc_zero),
    .prox(prox), .mv_done(mv_done), .pos(pos));

  always #2.5 clk_sys = ~clk_sys;

  // log every move request so the whole sequence can be judged afterwards
  always @(posedge clk_sys) begin
    if (mv_req === 1'b1 && n < 8) begin
      lv[n] = mv_vel;
      ld[n] = mv_dist;
      lr[n] = mv_dir;
      lc[n] = mv_cont;
      n++;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // apb cycle; data and error are taken only at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start(input logic sw);
    apb(1'b1, OFS_CTRL, {29'h0, 1'b1, sw, 1'b1});
    seek <= 1'b1;
    @(posedge clk_sys);
    seek <= 1'b0;
  endtask : start

  // one homing run with the edge d pulses past the proximity exit
  task automatic run_case(input int d, input logic sw, input int dly, input logic [1:0] res,
                          input logic poke);
    z = (pos / 200 + 2) * 200;
    prox_at <= 32'(z - d);
    done_dly <= dly;
    n = 0;
    start(sw);
    if (poke) apb(1'b1, OFS_OFS_DIST, 32'h0000_0099);
    do @(posedge clk_sys); while (busy !== 1'b0);
    apb(1'b0, OFS_MEAS, 32'h0);
    `CHK(rdat, 32'(d))
    apb(1'b0, OFS_INTERVAL, 32'h0);
    `CHK(rdat, 32'd200)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rdat[3:2], res)
    `CHK(homing_result, res)
    `CHK(homed_ok, res != 2'h3)
    if (res == 2'h3) begin
      `CHK({rdat[4], n}, {1'b1, 32'd0})
    end else begin
      `CHK(n, sw ? 5 : 4)
      `CHK({lc[0], lr[0], ld[0], lv[0]}, {2'b00, 32'd100, 32'h111})
      `CHK({lc[1], lr[1], lv[1]}, {2'b11, 32'h111})
      `CHK({lc[2], lr[2], lv[2]}, {2'b00, INT_VEL})
      if (sw) `CHK({lr[3], ld[3], lv[3]}, {1'b1, 32'h7, INT_VEL})
      `CHK({lr[n-1], ld[n-1], lv[n-1]}, {1'b1, 32'h33, 32'h222})
      `CHK(pos, z + (sw ? 58 : 51))
      apb(1'b0, OFS_COORD, 32'h0);
      `CHK(rdat, 32'h0000_ABCD)
    end
  endtask : run_case

  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {clk_sys, psel, penable, pwrite, seek, paddr, pwdata, prox_at, done_dly} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b1, OFS_VEL_SENSE, 32'h0000_0111);
    apb(1'b1, OFS_VEL_OFS, 32'h0000_0222);
    apb(1'b1, OFS_OFS_DIST, 32'h0000_0033);
    apb(1'b1, OFS_DONE_CMD, 32'h0000_ABCD);
    apb(1'b1, OFS_CORR_DIST, 32'h0000_0007);
    for (int k = 0; k < 10; k++) begin
      run_case(rows[k].d, rows[k].sw, rows[k].dly, rows[k].res, 1'b0);
      $display("case %0d done", k);
    end
    // settings written mid-run must not reach the offset move
    run_case(60, 1'b0, 5, 2'h1, 1'b1);
    $display("busy write case done");
    // reset in mid-run, then every register back at its reset value
    start(1'b0);
    repeat (40) @(posedge clk_sys);
    `CHK(busy, 1'b1)
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a <= 36; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      `CHK(rdat, (a == 8) ? RST_VEL_SENSE : (a == 12) ? RST_VEL_OFS : RST_ZERO)
    end
    `CHK({busy, homed_ok, homing_result}, 4'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    $display("reset case done");
    tally_and_finish();
  end
endmodule : tb

bind homing_zero_edge_sequencer homing_checker chk_u (.clk_sys(clk_sys), .rst(rst),
  .mv_req(mv_req), .mv_cont(mv_cont), .mv_stop(mv_stop), .mv_dir(mv_dir), .mv_vel(mv_vel),
  .busy(busy), .homed_ok(homed_ok), .homing_result(homing_result));
